//--- hw/adc_ctrl_map.svh
// Purpose: Named constants of the conversion control block.
// Assumes: Included by bare name from the package, the control module and the bench monitor.
// Notes: Times are in nanoseconds and turn into cycles where they are used.
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define WORD_W 16
`define CHANNELS 8
`define FIFO_DEPTH 16
`define CLK_PERIOD_NS 4
`define CONV_TIME_NS 4000
`define VALID_DELAY_NS 25

`define PIN_START_A 0
`define PIN_START_B 1
`define PIN_RESET 2
`define PIN_CS_N 3
`define PIN_RD_SCLK 4
`define PIN_RANGE 5
`define PIN_SERIAL 6
`define PIN_COUNT 7
`define PIN_IDLE 7'h18

`endif

//--- hw/adc_ctrl_pkg.sv
// Purpose: Types shared by the conversion control modules.
// Assumes: The constant header is on the include path.
// Notes: States follow a Gray sequence along the conversion path, except the direct CONV_IDLE to CONV_RUN step.
package adc_ctrl_pkg;
`include "adc_ctrl_map.svh"

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_ARMED = 2'b01,
    CONV_RUN = 2'b11,
    CONV_PUSH = 2'b10
  } conv_state_e;

  typedef logic [`WORD_W-1:0] sample_t;
endpackage

//--- hw/pin_sync.sv
// Purpose: Two-flop synchronisers with edge detection for host pins.
// Assumes: Pins are asynchronous to ref_clk.
// Notes: Edges are found on the second and third stages only; reset loads the idle levels.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          meta[i] <= IDLE[i];
          level[i] <= IDLE[i];
          prev[i] <= IDLE[i];
        end else begin
          meta[i] <= pins_in[i];
          level[i] <= meta[i];
          prev[i] <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev[i];
      assign fall[i] = ~level[i] & prev[i];
    end
  endgenerate
endmodule

//--- hw/sample_fifo.sv
// Purpose: Result FIFO between the converter and the output registers.
// Assumes: Single clock, flush clears all contents.
// Notes: Full and empty are exact; no write when full, no read when empty.
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end
  end
endmodule

//--- hw/adc_conv_ctrl.sv
// Purpose: Conversion control and result readout of a simultaneous-sampling converter.
// Assumes: Host pins are asynchronous and are sampled by ref_clk; sample_in is on ref_clk.
// Notes: Results pass a FIFO into the output registers, which drain only between frames.
//
// Contract
// (RULE1) Range pin high selects wide span, low narrow.
// (RULE2) Range changes take effect immediately.
// (RULE3) Host avoids range changes during conversions.
// (RULE4) Start rising edge holds its channel group.
// (RULE5) Start A owns lower half, B upper.
// (RULE6) Separate starts only without oversampling.
// (RULE7) Host may tie both starts together.
// (RULE8) Reset pin rising edge resets all logic; range_wide and the pin synchronisers reset only on srst.
// (RULE9) Host pulses reset after power-up.
// (RULE10) Reset during conversion aborts it.
// (RULE11) Reset during readout zeroes output registers.
// (RULE12) Parallel bus driven only while chip-select and read low.
// (RULE13) Chip-select fall enables serial outputs, MSB first.
// (RULE14) Serial clock rise shifts next bit out.
// (RULE15) Busy rises after both start edges.
// (RULE16) Busy falls on latching; results valid after delay.
// (RULE17) Host finishes busy-time reads before busy falls.
// (RULE18) Start edges ignored while busy.
// (RULE19) Marker three-stated while chip-select high.
// (RULE20) Parallel marker high for channel 1 read.
// (RULE21) Serial marker low at sixteenth falling clock.
// (RULE22) Serial channels sixteen bits, MSB first, back-to-back.
`timescale 1ns/10ps
`include "adc_ctrl_map.svh"
module adc_conv_ctrl import adc_ctrl_pkg::*; #(
  parameter int CHANNELS = `CHANNELS,
  parameter int FIFO_DEPTH = `FIFO_DEPTH,
  parameter int CONV_TIME_NS = `CONV_TIME_NS,
  parameter int VALID_DELAY_NS = `VALID_DELAY_NS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start_group_a,
  input wire logic start_group_b,
  input wire logic reset_pin,
  input wire logic cs_n,
  input wire logic rd_n_sclk,
  input wire logic range_sel,
  input wire logic serial_sel,
  input wire logic [CHANNELS*`WORD_W-1:0] sample_in,
  output logic range_wide,
  output logic hold_group_a,
  output logic hold_group_b,
  output logic busy,
  output logic results_valid,
  output logic [`WORD_W-1:0] parallel_result_bus_out,
  output logic parallel_result_bus_oe,
  output logic dout_a,
  output logic dout_b,
  output logic dout_oe,
  output logic first_channel_marker_out,
  output logic first_channel_marker_oe
);
  localparam int HALF = CHANNELS / 2;
  localparam int IDX_W = $clog2(CHANNELS);
  localparam int CONV_CYCLES = (CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int VALID_CYCLES = (VALID_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int CONV_W = $clog2(CONV_CYCLES + 1);
  localparam int VALID_W = $clog2(VALID_CYCLES + 1);
  localparam int BIT_W = $clog2(`WORD_W);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.
  ////////////////////////////////////////////////////////////////////////////////
  logic [`PIN_COUNT-1:0] pins;
  logic [`PIN_COUNT-1:0] lvl;
  logic [`PIN_COUNT-1:0] rise;
  logic [`PIN_COUNT-1:0] fall;

  assign pins = {serial_sel, range_sel, rd_n_sclk, cs_n, reset_pin, start_group_b, start_group_a};

  pin_sync #(
    .WIDTH(`PIN_COUNT),
    .IDLE(`PIN_IDLE)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pins_in(pins),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  wire host_reset = rise[`PIN_RESET];
  wire clear = srst | host_reset; // RULE8
  wire frame_off = lvl[`PIN_CS_N];
  wire serial_mode = lvl[`PIN_SERIAL];
  wire sclk_rise = rise[`PIN_RD_SCLK] & ~frame_off & serial_mode;
  wire sclk_fall = fall[`PIN_RD_SCLK] & ~frame_off & serial_mode;
  wire rd_fall = fall[`PIN_RD_SCLK] & ~frame_off & ~serial_mode;
  wire frame_start = fall[`PIN_CS_N];

  ////////////////////////////////////////////////////////////////////////////////
  // Input span selection.
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      range_wide <= 1'b0;
    end else begin
      range_wide <= lvl[`PIN_RANGE]; // RULE1 RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing.
  ////////////////////////////////////////////////////////////////////////////////
  conv_state_e state;
  conv_state_e next_state;
  logic seen_a;
  logic seen_b;
  logic [CONV_W-1:0] conv_cnt;
  logic [IDX_W-1:0] push_idx;
  sample_t held [CHANNELS];

  wire idle_like = (state == CONV_IDLE) || (state == CONV_ARMED);
  wire take_a = rise[`PIN_START_A] & idle_like; // RULE18
  wire take_b = rise[`PIN_START_B] & idle_like; // RULE18
  wire both_seen = (seen_a | take_a) & (seen_b | take_b);
  wire conv_done = (conv_cnt == CONV_W'(CONV_CYCLES - 1));
  wire fifo_in_ready;
  wire push_fire = (state == CONV_PUSH) & fifo_in_ready;
  wire push_last = push_fire & (push_idx == IDX_W'(CHANNELS - 1));

  always_comb begin
    next_state = state;
    case (state)
      CONV_IDLE: begin
        if (both_seen) begin
          next_state = CONV_RUN;
        end else if (take_a | take_b) begin
          next_state = CONV_ARMED;
        end
      end
      CONV_ARMED: begin
        if (both_seen) begin
          next_state = CONV_RUN;
        end
      end
      CONV_RUN: begin
        if (conv_done) begin
          next_state = CONV_PUSH;
        end
      end
      CONV_PUSH: begin
        if (push_last) begin
          next_state = CONV_IDLE;
        end
      end
      default: begin
        next_state = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      state <= CONV_IDLE; // RULE10
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear || next_state == CONV_IDLE) begin
      seen_a <= 1'b0;
      seen_b <= 1'b0;
      hold_group_a <= 1'b0;
      hold_group_b <= 1'b0;
    end else begin
      if (take_a) begin
        seen_a <= 1'b1;
        hold_group_a <= 1'b1; // RULE4
      end
      if (take_b) begin
        seen_b <= 1'b1;
        hold_group_b <= 1'b1; // RULE4
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_hold
      wire grab = (c < HALF) ? take_a : take_b; // RULE5
      always_ff @(posedge ref_clk) begin
        if (clear) begin
          held[c] <= '0;
        end else if (grab) begin
          held[c] <= sample_in[c*`WORD_W +: `WORD_W];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (clear || state != CONV_RUN) begin
      conv_cnt <= '0;
    end else if (!conv_done) begin
      conv_cnt <= conv_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear || state != CONV_PUSH) begin
      push_idx <= '0;
    end else if (push_fire) begin
      push_idx <= push_idx + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      busy <= 1'b0;
    end else if (idle_like && both_seen) begin
      busy <= 1'b1; // RULE15
    end else if (push_last) begin
      busy <= 1'b0; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result FIFO and output registers.
  ////////////////////////////////////////////////////////////////////////////////
  wire fifo_out_valid;
  sample_t fifo_out_data;
  wire drain_fire = fifo_out_valid & frame_off;
  logic [IDX_W-1:0] drain_idx;
  sample_t out_reg [CHANNELS];
  logic [VALID_W-1:0] valid_cnt;

  sample_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .flush(host_reset),
    .in_valid(state == CONV_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(held[push_idx]),
    .out_valid(fifo_out_valid),
    .out_ready(frame_off),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      drain_idx <= '0;
    end else if (drain_fire) begin
      drain_idx <= (drain_idx == IDX_W'(CHANNELS - 1)) ? '0 : drain_idx + 1'b1;
    end
  end

  generate
    for (c = 0; c < CHANNELS; c++) begin : g_out
      always_ff @(posedge ref_clk) begin
        if (clear) begin
          out_reg[c] <= '0; // RULE11
        end else if (drain_fire && drain_idx == IDX_W'(c)) begin
          out_reg[c] <= fifo_out_data; // RULE16
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (clear || busy) begin
      valid_cnt <= '0;
      results_valid <= 1'b0;
    end else if (state == CONV_IDLE && !fifo_out_valid && valid_cnt != VALID_W'(VALID_CYCLES)) begin
      valid_cnt <= valid_cnt + 1'b1;
    end else if (valid_cnt == VALID_W'(VALID_CYCLES)) begin
      results_valid <= 1'b1; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parallel readout.
  ////////////////////////////////////////////////////////////////////////////////
  logic [IDX_W-1:0] rd_idx;
  wire rd_wrap = (rd_idx == IDX_W'(CHANNELS - 1));
  wire par_drive = ~serial_mode & ~frame_off & ~lvl[`PIN_RD_SCLK];

  always_ff @(posedge ref_clk) begin
    if (clear || busy) begin
      rd_idx <= '0;
    end else if (rd_fall) begin
      rd_idx <= rd_wrap ? '0 : rd_idx + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      parallel_result_bus_out <= '0;
      parallel_result_bus_oe <= 1'b0;
    end else begin
      parallel_result_bus_oe <= par_drive; // RULE12
      if (rd_fall) begin
        parallel_result_bus_out <= out_reg[rd_idx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial readout.
  ////////////////////////////////////////////////////////////////////////////////
  sample_t shift_a;
  sample_t shift_b;
  logic [BIT_W-1:0] bit_cnt;
  logic [IDX_W-1:0] ser_ch;
  logic [BIT_W:0] sclk_fall_cnt;
  wire word_end = (bit_cnt == BIT_W'(`WORD_W - 1));
  wire ser_more = (ser_ch < IDX_W'(HALF));
  wire [IDX_W-1:0] ser_b_idx = IDX_W'(HALF) + ser_ch;
  wire [IDX_W-1:0] first_b_idx = IDX_W'(HALF);
  sample_t next_a;
  sample_t next_b;

  assign next_a = ser_more ? out_reg[ser_ch] : '0;
  assign next_b = ser_more ? out_reg[ser_b_idx] : '0;

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      shift_a <= '0;
      shift_b <= '0;
      bit_cnt <= '0;
      ser_ch <= '0;
    end else if (frame_start && serial_mode) begin
      shift_a <= out_reg[0]; // RULE13
      shift_b <= out_reg[first_b_idx];
      bit_cnt <= '0;
      ser_ch <= IDX_W'(1);
    end else if (sclk_rise && word_end) begin
      shift_a <= next_a; // RULE22
      shift_b <= next_b;
      bit_cnt <= '0;
      ser_ch <= ser_more ? ser_ch + 1'b1 : ser_ch;
    end else if (sclk_rise) begin
      shift_a <= {shift_a[`WORD_W-2:0], 1'b0}; // RULE14
      shift_b <= {shift_b[`WORD_W-2:0], 1'b0};
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      dout_a <= 1'b0;
      dout_b <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= serial_mode & ~frame_off; // RULE13
      if (frame_start && serial_mode) begin
        dout_a <= out_reg[0][`WORD_W-1]; // RULE13
        dout_b <= out_reg[first_b_idx][`WORD_W-1];
      end else if (sclk_rise && word_end) begin
        dout_a <= next_a[`WORD_W-1]; // RULE22
        dout_b <= next_b[`WORD_W-1];
      end else if (sclk_rise) begin
        dout_a <= shift_a[`WORD_W-2]; // RULE14
        dout_b <= shift_b[`WORD_W-2];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear || frame_start) begin
      sclk_fall_cnt <= '0;
    end else if (sclk_fall && sclk_fall_cnt != (BIT_W+1)'(`WORD_W)) begin
      sclk_fall_cnt <= sclk_fall_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // First-channel marker.
  ////////////////////////////////////////////////////////////////////////////////
  wire marker_ser_end = sclk_fall && sclk_fall_cnt == (BIT_W+1)'(`WORD_W - 1);

  always_ff @(posedge ref_clk) begin
    if (clear) begin
      first_channel_marker_out <= 1'b0;
      first_channel_marker_oe <= 1'b0;
    end else begin
      first_channel_marker_oe <= ~frame_off; // RULE19
      if (frame_start && serial_mode) begin
        first_channel_marker_out <= 1'b1; // RULE21
      end else if (marker_ser_end) begin
        first_channel_marker_out <= 1'b0; // RULE21
      end else if (rd_fall) begin
        first_channel_marker_out <= (rd_idx == '0); // RULE20
      end
    end
  end
endmodule

//--- bench/adc_conv_monitor.sv
// Purpose: Concurrent checks on the ports of the conversion control block.
// Assumes: Pins settle four ref_clk edges after they change; conversion is 10 cycles plus 8 pushes.
// Notes: Bound into every instance of the top module.
`timescale 1ns/10ps
`include "adc_ctrl_map.svh"
module adc_conv_monitor import adc_ctrl_pkg::*; #(
  parameter int CHANNELS = `CHANNELS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start_group_a,
  input wire logic start_group_b,
  input wire logic reset_pin,
  input wire logic cs_n,
  input wire logic rd_n_sclk,
  input wire logic range_sel,
  input wire logic serial_sel,
  input wire logic [CHANNELS*`WORD_W-1:0] sample_in,
  input wire logic range_wide,
  input wire logic hold_group_a,
  input wire logic hold_group_b,
  input wire logic busy,
  input wire logic results_valid,
  input wire logic [`WORD_W-1:0] parallel_result_bus_out,
  input wire logic parallel_result_bus_oe,
  input wire logic dout_a,
  input wire logic dout_b,
  input wire logic dout_oe,
  input wire logic first_channel_marker_out,
  input wire logic first_channel_marker_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  AST_RANGE_HI: assert property (range_sel [*5] |-> range_wide) else $error("span not wide");
  AST_RANGE_LO: assert property (!range_sel [*5] |-> !range_wide) else $error("span not narrow");
  AST_BUS_OFF: assert property ((cs_n || rd_n_sclk) [*5] |-> !parallel_result_bus_oe) else $error("bus driven");
  AST_BUS_ON: assert property ((!cs_n && !rd_n_sclk && !serial_sel && !reset_pin) [*5] |-> parallel_result_bus_oe)
    else $error("bus not driven");
  AST_SER_OFF: assert property (cs_n [*5] |-> !dout_oe && !first_channel_marker_oe) else $error("driven idle");
  AST_MARK_ON: assert property ((!cs_n && !reset_pin) [*5] |-> first_channel_marker_oe)
    else $error("marker not driven");
  AST_HOLD_A: assert property ($rose(hold_group_a) |-> $past(start_group_a, 3)) else $error("hold a no start");
  AST_HOLD_B: assert property ($rose(hold_group_b) |-> $past(start_group_b, 3)) else $error("hold b no start");
  AST_BUSY_BOTH: assert property ($rose(busy) |-> hold_group_a && hold_group_b) else $error("busy early");
  AST_BUSY_LEN: assert property ($rose(busy) ##1 !reset_pin [*8] ##1 !reset_pin [*8] |-> busy)
    else $error("busy short");
  AST_BUSY_END: assert property ($rose(busy) |-> ##[17:400] !busy) else $error("busy stuck");
  AST_IGNORE: assert property ($past(busy) && busy |-> !$rose(hold_group_a) && !$rose(hold_group_b))
    else $error("start taken while busy");
  AST_VALID_DLY: assert property ($fell(busy) |-> !results_valid [*7]) else $error("valid too soon");
  AST_ABORT: assert property ($rose(reset_pin) ##1 reset_pin [*2] |-> ##[1:3] !busy && !hold_group_a && !hold_group_b)
    else $error("no abort");
  AST_CLEAR: assert property ($rose(reset_pin) ##1 reset_pin [*2] |-> ##[1:3] parallel_result_bus_out == '0)
    else $error("output not cleared");
  ////////////////////////////////////////////////////////////////////////////
  COV_DONE: cover property ($fell(busy));
  COV_SER_MARK: cover property ($fell(first_channel_marker_out) && !cs_n && serial_sel);
  COV_PAR_FIRST: cover property (parallel_result_bus_oe && first_channel_marker_out);
endmodule

bind adc_conv_ctrl adc_conv_monitor #(.CHANNELS(CHANNELS)) u_mon (.ref_clk(ref_clk), .srst(srst),
  .start_group_a(start_group_a), .start_group_b(start_group_b), .reset_pin(reset_pin), .cs_n(cs_n),
  .rd_n_sclk(rd_n_sclk), .range_sel(range_sel), .serial_sel(serial_sel), .sample_in(sample_in),
  .range_wide(range_wide), .hold_group_a(hold_group_a), .hold_group_b(hold_group_b), .busy(busy),
  .results_valid(results_valid), .parallel_result_bus_out(parallel_result_bus_out),
  .parallel_result_bus_oe(parallel_result_bus_oe), .dout_a(dout_a), .dout_b(dout_b), .dout_oe(dout_oe),
  .first_channel_marker_out(first_channel_marker_out), .first_channel_marker_oe(first_channel_marker_oe));

//--- bench/adc_host_model.sv
// Purpose: Host that starts conversions and reads results over the pins.
// Assumes: Called at falling edges of ref_clk; the serial clock idles high between frames.
// Notes: Resolves the parallel bus and marker three-state outputs into wire levels.
`timescale 1ns/10ps
module adc_host_model import adc_ctrl_pkg::*; (
  input wire logic ref_clk,
  output logic start_group_a,
  output logic start_group_b,
  output logic reset_pin,
  output logic cs_n,
  output logic rd_n_sclk,
  input wire logic [15:0] bus_out,
  input wire logic bus_oe,
  input wire logic mark_out,
  input wire logic mark_oe,
  output wire logic [15:0] data_bus,
  output wire logic marker
);
  assign data_bus = bus_oe ? bus_out : 16'hzzzz;
  assign marker = mark_oe ? mark_out : 1'bz;
  initial begin
    start_group_a = 1'b0;
    start_group_b = 1'b0;
    reset_pin = 1'b0;
    cs_n = 1'b1;
    rd_n_sclk = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task start(input logic a, input logic b);
    start_group_a = a;
    start_group_b = b;
    cyc(6);
    start_group_a = 1'b0;
    start_group_b = 1'b0;
    cyc(4);
  endtask
  task frame(input logic v);
    cs_n = v;
    cyc(6);
  endtask
  task strobe(input logic v, input int n);
    rd_n_sclk = v;
    cyc(n);
  endtask
  task reset_pulse();
    reset_pin = 1'b1;
    cyc(15);
    reset_pin = 1'b0;
    cyc(6);
  endtask
endmodule

//--- bench/simultaneous_adc_conversion_control_bench.sv
// Purpose: Self-checking bench of the conversion control block.
// Assumes: Conversion time is shortened to ten cycles.
// Notes: Each scenario drives the pins and judges the outputs itself.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module simultaneous_adc_conversion_control_bench import adc_ctrl_pkg::*; ;
  localparam int CH = 8;
  int error_cnt = 0;
  int n_checks = 0;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic range_sel = 1'b0;
  logic serial_sel = 1'b0;
  logic [CH*16-1:0] sample_in = '0;
  logic start_a, start_b, reset_pin, cs_n, rd_n_sclk, range_wide, hold_group_a, hold_group_b, busy;
  logic results_valid, bus_oe, dout_a, dout_b, dout_oe, mark_out, mark_oe;
  sample_t bus_out;
  wire logic [15:0] data_bus;
  wire logic marker;
  always #2 ref_clk = ~ref_clk;
  adc_conv_ctrl #(.CHANNELS(CH), .CONV_TIME_NS(40)) u_dut (.ref_clk(ref_clk), .srst(srst),
    .start_group_a(start_a), .start_group_b(start_b), .reset_pin(reset_pin), .cs_n(cs_n),
    .rd_n_sclk(rd_n_sclk), .range_sel(range_sel), .serial_sel(serial_sel), .sample_in(sample_in),
    .range_wide(range_wide), .hold_group_a(hold_group_a), .hold_group_b(hold_group_b), .busy(busy),
    .results_valid(results_valid), .parallel_result_bus_out(bus_out), .parallel_result_bus_oe(bus_oe),
    .dout_a(dout_a), .dout_b(dout_b), .dout_oe(dout_oe), .first_channel_marker_out(mark_out),
    .first_channel_marker_oe(mark_oe));
  adc_host_model u_host (.ref_clk(ref_clk), .start_group_a(start_a), .start_group_b(start_b),
    .reset_pin(reset_pin), .cs_n(cs_n), .rd_n_sclk(rd_n_sclk), .bus_out(bus_out), .bus_oe(bus_oe),
    .mark_out(mark_out), .mark_oe(mark_oe), .data_bus(data_bus), .marker(marker));
  ////////////////////////////////////////////////////////////////////////////
  function automatic sample_t wexp(input int k, input int c);
    return sample_t'(16'h9c30 + k * 16'h0307 + c * 16'h1111) ^ {16{k[0]}};
  endfunction
  task load(input int k);
    for (int c = 0; c < CH; c++) sample_in[c*16+:16] = wexp(k, c);
  endtask
  task wait_done(input bit need_valid);
    int i;
    i = 0;
    u_host.cyc(6);
    while (busy !== 1'b0 && i < 500) begin
      u_host.cyc(1);
      i++;
    end
    while (need_valid && results_valid !== 1'b1 && i < 500) begin
      u_host.cyc(1);
      i++;
    end
    `CHK("done", 1'b1, i < 500)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_range();
    for (int v = 0; v < 2; v++) begin
      range_sel = v[0];
      u_host.cyc(5);
      `CHK("range_wide", v[0], range_wide)
    end
  endtask
  task t_split();
    load(1);
    u_host.start(1'b1, 1'b0);
    `CHK("hold_a", 1'b1, hold_group_a)
    `CHK("hold_b", 1'b0, hold_group_b)
    `CHK("busy", 1'b0, busy)
    load(2);
    u_host.start(1'b0, 1'b1);
    wait_done(1'b1);
    u_host.frame(1'b0);
    for (int c = 0; c <= CH; c++) begin
      u_host.strobe(1'b0, 6);
      `CHK("word", wexp((c % CH) < CH / 2 ? 1 : 2, c % CH), data_bus)
      `CHK("marker", c % CH == 0, marker)
      u_host.strobe(1'b1, 6);
      `CHK("bus_oe", 1'b0, bus_oe)
    end
    u_host.frame(1'b1);
    `CHK("mark_oe", 1'b0, mark_oe)
  endtask
  task t_serial();
    sample_t wa, wb;
    load(3);
    u_host.start(1'b1, 1'b1);
    load(4);
    u_host.start(1'b1, 1'b1);
    wait_done(1'b1);
    u_host.cyc(40);
    `CHK("busy", 1'b0, busy)
    serial_sel = 1'b1;
    u_host.cyc(5);
    u_host.frame(1'b0);
    `CHK("dout_oe", 1'b1, dout_oe)
    for (int j = 0; j < CH * 8; j++) begin
      u_host.strobe(1'b0, 10);
      wa = wexp(3, j / 16);
      wb = wexp(3, CH / 2 + j / 16);
      `CHK("dout_a", wa[15 - j % 16], dout_a)
      `CHK("dout_b", wb[15 - j % 16], dout_b)
      if (j < 16) `CHK("marker", j < 15, marker)
      u_host.strobe(1'b1, 10);
    end
    u_host.frame(1'b1);
    `CHK("dout_oe", 1'b0, dout_oe)
    serial_sel = 1'b0;
  endtask
  task t_abort();
    load(5);
    u_host.start(1'b1, 1'b1);
    `CHK("busy", 1'b1, busy)
    u_host.reset_pulse();
    `CHK("busy", 1'b0, busy)
    `CHK("hold_a", 1'b0, hold_group_a)
  endtask
  task t_clear();
    load(6);
    u_host.start(1'b1, 1'b1);
    wait_done(1'b1);
    u_host.frame(1'b0);
    u_host.strobe(1'b0, 6);
    `CHK("word", wexp(6, 0), data_bus)
    u_host.reset_pulse();
    `CHK("bus_out", 16'h0000, bus_out)
    u_host.strobe(1'b1, 6);
    u_host.frame(1'b1);
  endtask
  task t_stall();
    u_host.frame(1'b0);
    for (int n = 0; n < 3; n++) begin
      load(7 + n);
      u_host.start(1'b1, 1'b1);
      if (n < 2) wait_done(1'b0);
    end
    u_host.cyc(80);
    `CHK("busy", 1'b1, busy)
    u_host.frame(1'b1);
    wait_done(1'b1);
    u_host.reset_pulse();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    u_host.cyc(4);
    u_host.reset_pulse();
    t_range();
    t_split();
    t_serial();
    t_abort();
    t_clear();
    t_stall();
    finish_test();
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule
